// *** hw/isie_exec.sv ***
// decode and execute of the two increment-and-conditional-skip instructions
`include "isie_params.svh"
`default_nettype none
// Behaviour
// - Opcode 0011 11da ffff ffff is increment-skip-if-zero: f plus one, status flags untouched.
// - Destination bit 0 writes the result to the accumulator, 1 writes it back to f.
// - Increment-skip-if-zero with a zero result discards the next slot: two cycles in total.
// - Increment-skip-if-nonzero with a nonzero result discards the next slot; zero runs in one.
// - Opcode 0100 10da ffff ffff is increment-skip-if-nonzero: f plus one, flags untouched.
// - A skip over a two-word instruction discards two slots, three cycles in total.
// - Access bit 0 picks the access bank, 1 picks the bank named by the bank select register.
// - Access bit 0 with extended set enabled and f at most 5fh uses indexed literal offset.
// - A discarded slot does nothing in all four phases: no file, accumulator or flag change.
module isie_exec
  import isie_pkg::*;
#(
  parameter int BANK_W = 4
) (
  input  wire logic              clk,           // core clock, 250 MHz
  input  wire logic              rst,           // sync reset, active high
  input  wire logic [15:0]       instr,         // fetched instruction word
  input  wire logic              instr_valid,   // instr holds a first word this cycle
  input  wire logic              next_two_word, // prefetched next instr has two words
  input  wire logic [BANK_W-1:0] bank_sel,      // bank select register
  input  wire logic              ext_en,        // extended instruction set enabled
  input  wire logic [BANK_W+7:0] fsr2,          // index base for literal offset mode
  input  wire logic [7:0]        rf_rdata,      // register file read data
  output var  logic [BANK_W+7:0] rf_addr,       // register file address
  output var  logic              rf_re,         // read strobe, high in q2
  output var  logic              rf_we,         // write strobe, high in q4
  output var  logic [7:0]        rf_wdata,      // write data
  output var  logic [7:0]        acc,           // accumulator
  output var  logic              exec_hit,      // an increment-skip is executing
  output var  logic              slot_nop,      // current slot is discarded
  output isie_phase_t            phase          // current phase
);
  localparam int AW = BANK_W + 8;

  isie_slot_t     slot_ff, nxt_slot;
  logic           hit_ff, nxt_hit;
  logic           nz_ff, nxt_nz;
  logic           d_ff, nxt_d;
  logic [AW-1:0]  addr_ff, nxt_addr;
  logic           re_ff, nxt_re;
  logic           we_ff, nxt_we;
  logic [7:0]     opnd_ff, nxt_opnd;
  logic [7:0]     res_ff, nxt_res;
  logic [7:0]     wdata_ff, nxt_wdata;
  logic [7:0]     acc_ff, nxt_acc;
  logic [5:0]     op;
  logic [7:0]     f;
  logic           dec_z, dec_nz, skip;

  isie_phase u_phase (
    .clk   (clk),
    .rst   (rst),
    .phase (phase)
  );

  assign op     = instr[`ISIE_OP_HI:`ISIE_OP_LO];
  assign f      = instr[`ISIE_F_HI:`ISIE_F_LO];
  assign dec_z  = instr_valid && (op == `ISIE_OP_SKIP_Z);
  assign dec_nz = instr_valid && (op == `ISIE_OP_SKIP_NZ);
  // a zero result skips for one opcode, a nonzero result for the other
  assign skip   = hit_ff && (nz_ff ? (res_ff != 8'h00) : (res_ff == 8'h00));

  always_comb begin
    nxt_hit   = hit_ff;
    nxt_nz    = nz_ff;
    nxt_d     = d_ff;
    nxt_addr  = addr_ff;
    nxt_re    = 1'b0;
    nxt_we    = 1'b0;
    nxt_opnd  = opnd_ff;
    nxt_res   = res_ff;
    nxt_wdata = wdata_ff;
    nxt_acc   = acc_ff;
    nxt_slot  = slot_ff;
    unique case (phase)
      ISIE_Q1: begin
        // decode; discarded slots never decode what sits on instr
        nxt_hit = (slot_ff == ISIE_EXEC) && (dec_z || dec_nz);
        nxt_nz  = dec_nz;
        nxt_d   = instr[`ISIE_D_BIT];
        nxt_re  = nxt_hit;
        if (instr[`ISIE_A_BIT]) begin
          nxt_addr = {bank_sel, f};
        end else if (ext_en && (f <= `ISIE_IDX_MAX)) begin
          nxt_addr = fsr2 + {{BANK_W{1'b0}}, f};
        end else if (f <= `ISIE_IDX_MAX) begin
          nxt_addr = {`ISIE_ACC_LO_BANK, f};
        end else begin
          nxt_addr = {`ISIE_ACC_HI_BANK, f};
        end
      end
      ISIE_Q2: begin
        if (hit_ff) begin
          nxt_opnd = rf_rdata;
        end
      end
      ISIE_Q3: begin
        if (hit_ff) begin
          nxt_res = opnd_ff + 8'h01;
          // no status flag path exists here: flags stay as they were
          if (d_ff) begin
            nxt_we    = 1'b1;
            nxt_wdata = opnd_ff + 8'h01;
          end else begin
            nxt_acc = opnd_ff + 8'h01;
          end
        end
      end
      ISIE_Q4: begin
        nxt_hit = 1'b0;
        unique case (slot_ff)
          ISIE_EXEC: begin
            if (skip) begin
              nxt_slot = next_two_word ? ISIE_NOP2 : ISIE_NOP1;
            end
          end
          ISIE_NOP2: nxt_slot = ISIE_NOP1;
          ISIE_NOP1: nxt_slot = ISIE_EXEC;
          default:   nxt_slot = ISIE_EXEC;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slot_ff  <= ISIE_EXEC;
      hit_ff   <= 1'b0;
      nz_ff    <= 1'b0;
      d_ff     <= 1'b0;
      addr_ff  <= `ISIE_ADDR_RST;
      re_ff    <= 1'b0;
      we_ff    <= 1'b0;
      opnd_ff  <= 8'h00;
      res_ff   <= 8'h00;
      wdata_ff <= 8'h00;
      acc_ff   <= `ISIE_ACC_RST;
    end else begin
      slot_ff  <= nxt_slot;
      hit_ff   <= nxt_hit;
      nz_ff    <= nxt_nz;
      d_ff     <= nxt_d;
      addr_ff  <= nxt_addr;
      re_ff    <= nxt_re;
      we_ff    <= nxt_we;
      opnd_ff  <= nxt_opnd;
      res_ff   <= nxt_res;
      wdata_ff <= nxt_wdata;
      acc_ff   <= nxt_acc;
    end
  end

  assign rf_addr  = addr_ff;
  assign rf_re    = re_ff;
  assign rf_we    = we_ff;
  assign rf_wdata = wdata_ff;
  assign acc      = acc_ff;
  assign exec_hit = hit_ff;
  assign slot_nop = (slot_ff != ISIE_EXEC);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_dec_zero;
    (phase == ISIE_Q1) && !slot_nop && instr_valid && (op == 6'h0f) |=> rf_re && exec_hit;
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("zero-skip opcode not decoded");

  property p_dec_nonzero;
    (phase == ISIE_Q1) && !slot_nop && instr_valid && (op == 6'h12) |=> rf_re ##1 exec_hit;
  endproperty
  a_dec_nonzero: assert property (p_dec_nonzero) else $error("nonzero-skip missed");

  property p_dest;
    (phase == ISIE_Q3) && hit_ff |=> (d_ff ? (rf_we && rf_wdata == $past(opnd_ff) + 8'h01)
                                          : (!rf_we && acc == $past(opnd_ff) + 8'h01));
  endproperty
  a_dest: assert property (p_dest) else $error("result went to wrong destination");

  property p_skip_one;
    (phase == ISIE_Q4) && skip && !next_two_word |=>
      slot_nop [*4] ##1 !slot_nop;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("single skip slot wrong");

  property p_noskip;
    (phase == ISIE_Q4) && hit_ff && (nz_ff == (res_ff == 8'h00)) |=> !slot_nop [*4];
  endproperty
  a_noskip: assert property (p_noskip) else $error("skip taken when not due");

  property p_skip_two;
    (phase == ISIE_Q4) && skip && next_two_word |=> slot_nop [*8] ##1 !slot_nop;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip not two slots");

  property p_bank;
    (phase == ISIE_Q1) && instr[8] |=> rf_addr == {$past(bank_sel), $past(instr[7:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_index;
    (phase == ISIE_Q1) && !instr[8] && ext_en && (instr[7:0] <= 8'h5f)
      |=> rf_addr == $past(fsr2) + {{BANK_W{1'b0}}, $past(instr[7:0])};
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_nop_quiet;
    slot_nop |-> !rf_re && !rf_we && !exec_hit && $stable(acc);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("activity in discarded slot");

  property p_wrap;
    (phase == ISIE_Q3) && hit_ff && (opnd_ff == 8'hff) |=> res_ff == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("increment did not wrap");

  property p_phases;
    (rf_re |-> phase == ISIE_Q2) and (rf_we |-> phase == ISIE_Q4);
  endproperty
  a_phases: assert property (p_phases) else $error("strobe in wrong phase");

  c_skip_zero: cover property ((phase == ISIE_Q4) && skip && !nz_ff);
  c_skip_nz:   cover property ((phase == ISIE_Q4) && skip && nz_ff);
  c_skip_two:  cover property ((phase == ISIE_Q4) && skip && next_two_word);
  c_wr_back:   cover property (rf_we);
endmodule // isie_exec
`default_nettype wire

// *** hw/isie_params.svh ***
// constants for the increment-and-skip execution block
`ifndef ISIE_PARAMS_SVH
`define ISIE_PARAMS_SVH

`define ISIE_OP_HI       15
`define ISIE_OP_LO       10
`define ISIE_OP_SKIP_Z   6'h0f
`define ISIE_OP_SKIP_NZ  6'h12
`define ISIE_D_BIT       9
`define ISIE_A_BIT       8
`define ISIE_F_HI        7
`define ISIE_F_LO        0
`define ISIE_IDX_MAX     8'h5f
`define ISIE_ACC_LO_BANK 4'h0
`define ISIE_ACC_HI_BANK 4'hf
`define ISIE_ACC_RST     8'h00
`define ISIE_ADDR_RST    12'h000

`endif

// *** hw/isie_pkg.sv ***
// types shared by the increment-and-skip execution block
`default_nettype none
package isie_pkg;
  // gray order along q1 -> q2 -> q3 -> q4
  typedef enum logic [1:0] {
    ISIE_Q1 = 2'b00,
    ISIE_Q2 = 2'b01,
    ISIE_Q3 = 2'b11,
    ISIE_Q4 = 2'b10
  } isie_phase_t;
  // slot kind: normal execute or a discarded slot
  typedef enum logic [1:0] {
    ISIE_EXEC = 2'b00,
    ISIE_NOP1 = 2'b01,
    ISIE_NOP2 = 2'b11
  } isie_slot_t;
endpackage
`default_nettype wire

// *** hw/isie_phase.sv ***
// four-phase sequencer of one instruction cycle
`default_nettype none
module isie_phase
  import isie_pkg::*;
(
  input  wire logic        clk,   // core clock
  input  wire logic        rst,   // sync reset, active high
  output isie_phase_t      phase  // current phase q1..q4
);
  isie_phase_t phase_ff;
  isie_phase_t nxt_phase;

  always_comb begin
    unique case (phase_ff)
      ISIE_Q1: nxt_phase = ISIE_Q2;
      ISIE_Q2: nxt_phase = ISIE_Q3;
      ISIE_Q3: nxt_phase = ISIE_Q4;
      ISIE_Q4: nxt_phase = ISIE_Q1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= ISIE_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign phase = phase_ff;
endmodule // isie_phase
`default_nettype wire

// *** test/test_increment_skip_instr_exec.sv ***
// self-checking bench for the increment-and-skip execution block
`default_nettype none
module test_increment_skip_instr_exec
  import isie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [15:0] instr = 16'h0000;
  logic        instr_valid = 1'h0;
  logic        next_two_word = 1'h0;
  logic [3:0]  bank_sel = 4'h0;
  logic        ext_en = 1'h0;
  logic [11:0] fsr2 = 12'h000;
  logic [7:0]  rf_rdata = 8'h00;
  logic [11:0] rf_addr;
  logic        rf_re, rf_we, exec_hit, slot_nop;
  logic [7:0]  rf_wdata, acc;
  logic [7:0]  exp_acc = 8'h00;
  isie_phase_t phase;
  int          n_fail = 0;
  int          comparisons = 0;

  always #2 clk = ~clk;

  isie_exec #(.BANK_W(4)) dut (
    .clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .next_two_word(next_two_word), .bank_sel(bank_sel), .ext_en(ext_en), .fsr2(fsr2),
    .rf_rdata(rf_rdata), .rf_addr(rf_addr), .rf_re(rf_re), .rf_we(rf_we),
    .rf_wdata(rf_wdata), .acc(acc), .exec_hit(exec_hit), .slot_nop(slot_nop), .phase(phase)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // bounded wait for a q1 that is not a discarded slot
  task automatic wait_q1;
    int i;
    for (i = 0; i < 20 && !(phase === ISIE_Q1 && slot_nop === 1'b0); i++) @(negedge clk);
    if (i == 20) begin
      n_fail++;
      $display("[FAIL] %0t no free q1 cycle", $time);
      conclude();
    end
  endtask

  function automatic logic [11:0] ea(input logic a, input logic [7:0] f, input logic ext);
    if (a)
      return {bank_sel, f};
    if (ext && f <= 8'h5f)
      return fsr2 + {4'h0, f};
    return {(f <= 8'h5f) ? 4'h0 : 4'hf, f};
  endfunction

  task automatic run(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
                     input logic [7:0] v, input logic ext, input logic two);
    logic [7:0]  res;
    logic        skip;
    logic [15:0] nops;
    logic [15:0] hits;
    res = v + 8'h01;
    skip = (op == 6'h0f) ? (res == 8'h00) : (res != 8'h00);
    wait_q1();
    instr = {op, d, a, f};
    instr_valid = 1'h1;
    ext_en = ext;
    next_two_word = two;
    rf_rdata = v;
    @(negedge clk);
    instr_valid = 1'h0;
    chk({12'h000, phase, rf_re, exec_hit}, {12'h000, ISIE_Q2, 2'h3}, "read in q2");
    chk({4'h0, rf_addr}, {4'h0, ea(a, f, ext)}, "operand address");
    @(negedge clk);
    // read data is only valid in q2; a late sample would see the inverse
    rf_rdata = ~v;
    @(negedge clk);
    chk({12'h000, phase, rf_we, rf_re}, {12'h000, ISIE_Q4, d, 1'h0}, "q4 write");
    if (d)
      chk({8'h00, rf_wdata}, {8'h00, res}, "write data");
    else
      exp_acc = res;
    chk({8'h00, acc}, {8'h00, exp_acc}, "accumulator");
    nops = 16'h0000;
    hits = 16'h0000;
    // offer the same instruction while slots are discarded: it must be ignored
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      nops = nops + {15'h0000, slot_nop === 1'b1};
      hits = hits + {15'h0000, rf_re === 1'b1 || rf_we === 1'b1 || exec_hit === 1'b1};
      instr_valid = slot_nop;
    end
    chk(nops, skip ? (two ? 16'h0008 : 16'h0004) : 16'h0000, "discards");
    chk(hits, 16'h0000, "activity in discarded slot");
    chk({8'h00, acc}, {8'h00, exp_acc}, "accumulator after slot");
  endtask

  task automatic s_skip_zero;
    bank_sel = 4'h5;
    run(6'h0f, 1'h1, 1'h0, 8'h10, 8'hff, 1'h0, 1'h0);
    run(6'h0f, 1'h0, 1'h1, 8'h80, 8'h41, 1'h0, 1'h0);
    $display("skip-if-zero test done");
  endtask

  task automatic s_skip_nonzero;
    run(6'h12, 1'h0, 1'h0, 8'h70, 8'h07, 1'h0, 1'h0);
    run(6'h12, 1'h1, 1'h1, 8'h05, 8'hff, 1'h0, 1'h0);
    $display("skip-if-nonzero test done");
  endtask

  task automatic s_two_word;
    run(6'h0f, 1'h1, 1'h0, 8'h20, 8'hff, 1'h0, 1'h1);
    run(6'h12, 1'h0, 1'h1, 8'h33, 8'h00, 1'h0, 1'h1);
    $display("two-word skip test done");
  endtask

  task automatic s_indexed;
    fsr2 = 12'h100;
    run(6'h0f, 1'h1, 1'h0, 8'h5f, 8'h01, 1'h1, 1'h0);
    run(6'h12, 1'h0, 1'h0, 8'h60, 8'h80, 1'h1, 1'h0);
    run(6'h0f, 1'h0, 1'h1, 8'h00, 8'h02, 1'h1, 1'h0);
    $display("indexed address test done");
  endtask

  // a foreign opcode in q1, then a valid opcode offered outside q1
  task automatic s_ignored;
    wait_q1();
    instr = 16'h2810;
    instr_valid = 1'h1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      chk({13'h0000, rf_re, rf_we, exec_hit}, 16'h0000, "ignored request");
      instr = 16'h3c10;
    end
    instr_valid = 1'h0;
    $display("ignored request test done");
  endtask

  initial begin
    repeat (16) @(negedge clk);
    chk({3'h0, phase, acc, rf_re, rf_we, slot_nop}, 16'h0000, "reset state");
    rst = 1'h0;
    s_skip_zero();
    s_skip_nonzero();
    s_two_word();
    s_indexed();
    s_ignored();
    conclude();
  end
endmodule // test_increment_skip_instr_exec
`default_nettype wire
